// ==== bench/ppm_host_model.sv ====
// ppm_host_model.sv: host side of the configuration bus and the event source
// assumes ppm_top timing: one byte access taken per edge, read answer next cycle
`timescale 1ns/1ns
`default_nettype none
module ppm_host_model
   import ppm_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] cfg_rdata_q,
   input  wire logic       cfg_rvalid_q,
   output var ppm_cfg_req_s cfg_req,
   output logic            wake_src
);
   initial begin
      cfg_req = '0;
      wake_src = 1'b0;
   end
   // ************************************************************
   // one byte access, held until the taking edge
   // ************************************************************
   // host writes: cold-wake clear, flag clear by one, state select
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      int n;
      rdata = 8'hEE;
      @(posedge clk_sys);
      cfg_req.wr <= wr;
      cfg_req.rd <= ~wr;
      cfg_req.addr <= addr;
      cfg_req.wdata <= wdata;
      @(posedge clk_sys);
      cfg_req.wr <= 1'b0;
      cfg_req.rd <= 1'b0;
      // released lines flip so a stale value never looks valid
      cfg_req.addr <= ~addr;
      cfg_req.wdata <= ~wdata;
      for (n = 0; n < 4 && !wr; n++) begin
         @(negedge clk_sys);
         if (cfg_rvalid_q === 1'b1) begin
            rdata = cfg_rdata_q;
            break;
         end
      end
   endtask
   task automatic pulse_event();
      @(posedge clk_sys);
      wake_src <= 1'b1;
      @(posedge clk_sys);
      wake_src <= 1'b0;
   endtask
endmodule // ppm_host_model
`default_nettype wire

// ==== bench/test_pci_power_mgmt_capability.sv ====
// test_pci_power_mgmt_capability.sv: self-checking bench for ppm_top
// assumes ppm_host_model drives cfg_req and wake_src; clk_sys and rstn are driven here
`timescale 1ns/1ns
`default_nettype none
module test_pci_power_mgmt_capability
   import ppm_pkg::*;
;
   logic         clk_sys;
   logic         rstn;
   ppm_cfg_req_s cfg_req;
   logic         wake_src;
   logic [7:0]   cfg_rdata_q;
   logic         cfg_rvalid_q;
   logic         wake_n_q;
   logic [1:0]   power_state_q;
   logic         func_rst_q;
   logic [15:0]  legacy_base_q;
   int           errors;
   int           tests_run;
   logic [15:0]  rnd;
   logic         seen;
   int           i;

   ppm_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .cfg_req(cfg_req), .wake_src(wake_src),
      .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .wake_n_q(wake_n_q),
      .power_state_q(power_state_q), .func_rst_q(func_rst_q), .legacy_base_q(legacy_base_q));
   ppm_host_model i_host (.clk_sys(clk_sys), .cfg_rdata_q(cfg_rdata_q),
      .cfg_rvalid_q(cfg_rvalid_q), .cfg_req(cfg_req), .wake_src(wake_src));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;
   // ************************************************************
   // expectations and helpers
   // ************************************************************
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [7:0] caps_byte(input logic cold, input logic hi);
      logic [15:0] c;
      c = {cold, 4'hF, 1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 1'b0, 3'h2};
      return hi ? c[15:8] : c[7:0];
   endfunction
   function automatic logic [7:0] csr_hi(input logic flag, input logic en);
      return {flag, 6'h00, en};
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      i_host.xfer(1'b0, a, 8'h00, d);
      check(d, exp, what);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      i_host.xfer(1'b1, a, d, dummy);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog: whole run is under two hundred cycles
   initial begin
      #200000;
      errors++;
      summarize();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      errors = 0;
      tests_run = 0;
      rnd = 16'h46CB; // seed 18123
      rstn = 1'b0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_chk(8'hA1, 8'h00, "next pointer");
      rd_chk(8'hA2, caps_byte(1'b1, 1'b0), "caps low");
      rd_chk(8'hA3, caps_byte(1'b1, 1'b1), "caps high");
      rd_chk(8'hA4, 8'h00, "csr low");
      rd_chk(8'hA5, 8'h00, "csr high");
      rd_chk(8'h50, 8'h00, "unmapped");
      rd_chk(8'hA0, 8'h01, "capability id");
      $display("reset values done");
      for (i = 0; i < 4; i++) begin
         rnd = lfsr_next(rnd);
         wr(8'hA1, rnd[7:0]);
         wr(8'hA2, rnd[7:0]);
         wr(8'hA3, rnd[15:8]);
         rd_chk(8'hA1, 8'h00, "next pointer");
         rd_chk(8'hA2, caps_byte(rnd[15], 1'b0), "caps low");
         rd_chk(8'hA3, caps_byte(rnd[15], 1'b1), "caps high");
      end
      wr(8'hA3, 8'h80);
      rd_chk(8'hA3, caps_byte(1'b1, 1'b1), "cold wake set");
      $display("capability writes done");
      wr(8'hA5, 8'h00);
      i_host.pulse_event();
      rd_chk(8'hA5, csr_hi(1'b1, 1'b0), "flag without enable");
      check(wake_n_q, 1'b1, "event gated off");
      wr(8'hA5, 8'h01);
      rd_chk(8'hA5, csr_hi(1'b1, 1'b1), "zero write keeps flag");
      check(wake_n_q, 1'b0, "event driven");
      wr(8'hA5, 8'h81);
      repeat (3) @(negedge clk_sys);
      check(wake_n_q, 1'b1, "event released on clear");
      rd_chk(8'hA5, csr_hi(1'b0, 1'b1), "flag cleared");
      i_host.pulse_event();
      repeat (3) @(negedge clk_sys);
      check(wake_n_q, 1'b0, "event on enabled flag");
      wr(8'hA5, 8'h00);
      repeat (3) @(negedge clk_sys);
      check(wake_n_q, 1'b1, "enable off releases");
      $display("event tests done");
      for (i = 0; i < 4; i++) begin
         rnd = lfsr_next(rnd);
         wr(8'hA4, {rnd[7:2], i[1:0]});
         rd_chk(8'hA4, {6'h00, i[1:0]}, "state field");
         check(power_state_q, i[1:0], "state output");
      end
      $display("state tests done");
      rnd = lfsr_next(rnd);
      wr(8'h44, rnd[7:0]);
      wr(8'h45, rnd[15:8]);
      wr(8'hA3, 8'h00);
      wr(8'hA5, 8'h01);
      i_host.pulse_event();
      wr(8'hA4, 8'h03);
      wr(8'hA4, 8'h00);
      seen = 1'b0;
      for (i = 0; i < 6; i++) begin
         @(negedge clk_sys);
         if (func_rst_q === 1'b1) begin
            seen = 1'b1;
         end
      end
      check(seen, 1'b1, "function reset pulse");
      rd_chk(8'hA5, csr_hi(1'b1, 1'b1), "csr kept");
      check(legacy_base_q, rnd, "legacy base kept");
      rd_chk(8'h44, rnd[7:0], "legacy low read");
      rd_chk(8'h45, rnd[15:8], "legacy high read");
      rd_chk(8'hA3, caps_byte(1'b0, 1'b1), "caps kept");
      check(wake_n_q, 1'b0, "event kept");
      $display("state reset tests done");
      summarize();
   end
endmodule // test_pci_power_mgmt_capability
`default_nettype wire

// ==== core/ppm_cap.sv ====
// ppm_cap.sv: power-state field of the power-management capability of one card-bridge function
// assumes byte-wide config accesses, one cycle each, read data a cycle later
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.svh"
module ppm_cap_state (
   input  wire logic  clk_sys,
   input  wire logic  rstn,
   input  wire logic  wr_en,
   input  wire logic  [1:0] wr_state,
   output logic       [1:0] state_q,
   output logic       wake_pulse_q
);
   // ************************************************************
   // power state, with a one-cycle pulse on D3hot to D0
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= 2'h0;
      end else if (wr_en) begin
         state_q <= wr_state;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wake_pulse_q <= 1'b0;
      end else begin
         wake_pulse_q <= wr_en && (state_q == 2'h3) && (wr_state == 2'h0);
      end
   end

   property p_wake;
      @(posedge clk_sys) disable iff (!rstn)
      (wr_en && state_q == 2'h3 && wr_state == 2'h0) |=> wake_pulse_q && state_q == 2'h0;
   endproperty
   a_wake: assert property (p_wake) else $error("missed D3hot to D0 reset pulse");
endmodule // ppm_cap_state
`default_nettype wire

// ==== core/ppm_defines.svh ====
// ppm_defines.svh: offsets, field positions, reset values for the power block
// assumes byte-addressed configuration space, one function per instance
// Function
// - next-item pointer byte always reads zero; single capability entry.
// - cold-state wake bit 15 is writable, resets to 1; firmware clears it.
// - capability bits 14 to 11 always read one.
// - capability bit 10 reads one: state D2 supported.
// - capability bit 9 reads one: state D1 supported.
// - capability bits 8 to 6 read zero.
// - capability bit 5 reads one: special initialisation needed.
// - capability bit 4 reports system-supplied auxiliary source for cold wake.
// - capability bit 3 reads zero: no bus clock needed for events.
// - capability bits 2 to 0 read 010 for revision 1.1.
// - each function supports states D0, D1, D2 and D3.
// - control/status word survives the internal D3hot to D0 reset.
// - D3hot to D0 resets standard registers, keeps vendor, power, 44h.
// - status bit 15 sets on any event, regardless of enable.
// - writing one to bit 15 clears it and the event; zero ignored.
// - data-scale and data-select fields read zero.
// - enable bit 8 gates the event output.
// - control/status bits 7 to 2 read zero.
// - state field bits 1:0 report and set power state, 00 to 11.
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
// ************************************************************
// offsets
// ************************************************************
`define PPM_OFS_CAP_ID     8'hA0
`define PPM_OFS_NEXT_PTR   8'hA1
`define PPM_OFS_CAPS_LO    8'hA2
`define PPM_OFS_CAPS_HI    8'hA3
`define PPM_OFS_CSR_LO     8'hA4
`define PPM_OFS_CSR_HI     8'hA5
`define PPM_OFS_LEGACY_LO  8'h44
`define PPM_OFS_LEGACY_HI  8'h45
// ************************************************************
// fields and reset values
// ************************************************************
`define PPM_CAP_ID_VAL     8'h01
`define PPM_NEXT_PTR_VAL   8'h00
`define PPM_CAPS_FIXED     16'h7E32
`define PPM_CAPS_RST       16'hFE12
`define PPM_CAP_COLD_BIT   15
`define PPM_AUX_SRC_BIT    4
`define PPM_AUX_SRC_DFLT   1'b1
`define PPM_CSR_STAT_BIT   15
`define PPM_CSR_EN_BIT     8
`define PPM_CSR_RST        16'h0000
`define PPM_LEGACY_RST     16'h0000
`endif

// ==== core/ppm_event_ctl.sv ====
// ppm_event_ctl.sv: sticky wake-event flag and gated active-low event pin
// assumes event sources are synchronous single-cycle or level requests
`timescale 1ns/1ns
`default_nettype none
module ppm_event_ctl (
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic event_req,
   input  wire logic clr_stat,
   input  wire logic enable,
   output logic      stat_q,
   output logic      wake_n_q
);
   // ************************************************************
   // sticky flag, set wins over a same-cycle clear
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stat_q <= 1'b0;
      end else if (event_req) begin
         stat_q <= 1'b1;
      end else if (clr_stat) begin
         stat_q <= 1'b0;
      end
   end

   // ************************************************************
   // pin: registered, so it follows the flag by one cycle
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wake_n_q <= 1'b1;
      end else begin
         wake_n_q <= ~(stat_q & enable);
      end
   end

   property p_pin_follows;
      @(posedge clk_sys) disable iff (!rstn)
      1'b1 |=> (wake_n_q == !($past(stat_q) && $past(enable)));
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("event pin wrong");

   property p_gate;
      @(posedge clk_sys) disable iff (!rstn)
      !enable |=> wake_n_q;
   endproperty
   a_gate: assert property (p_gate) else $error("event pin asserted while disabled");

   property p_set;
      @(posedge clk_sys) disable iff (!rstn)
      event_req |=> stat_q;
   endproperty
   a_set: assert property (p_set) else $error("event flag not set");

   property p_clear;
      @(posedge clk_sys) disable iff (!rstn)
      clr_stat && !event_req |=> !stat_q ##1 wake_n_q;
   endproperty
   a_clear: assert property (p_clear) else $error("event flag not cleared");
endmodule // ppm_event_ctl
`default_nettype wire

// ==== core/ppm_pkg.sv ====
// ppm_pkg.sv: types for the power-management capability block
// assumes ppm_defines.svh holds the numbers
`default_nettype none
package ppm_pkg;
   typedef enum logic [1:0] {
      PPM_D0     = 2'h0,
      PPM_D1     = 2'h1,
      PPM_D2     = 2'h2,
      PPM_D3HOT  = 2'h3
   } ppm_pstate_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ppm_cfg_req_s;

   typedef struct packed {
      logic       wake_event_flag;
      logic       wake_event_enable;
      logic [1:0] power_state_field;
   } ppm_csr_s;
endpackage
`default_nettype wire

// ==== core/ppm_top.sv ====
// ppm_top.sv: power-management capability register bank for one function
// assumes single-byte config reads and writes, synchronous to clk_sys
// the internal D3hot to D0 reset is issued here on func_rst_q; other
// register blocks of the function use it, this block ignores it
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.svh"
module ppm_top
   import ppm_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rstn,
   input  wire ppm_cfg_req_s  cfg_req,
   input  wire logic          wake_src,
   output logic        [7:0]  cfg_rdata_q,
   output logic               cfg_rvalid_q,
   output logic               wake_n_q,
   output logic        [1:0]  power_state_q,
   output logic               func_rst_q,
   output logic        [15:0] legacy_base_q
);
   logic       cold_wake_q;
   logic       aux_src_q;
   logic       aux_src_init_q;
   logic       stat_q;
   logic       enable_q;
   logic       wake_pulse;
   logic [1:0] state_q;
   logic [15:0] caps;
   ppm_csr_s   csr;
   logic [7:0] rd_d;
   logic       wr_csr_lo;
   logic       wr_csr_hi;

   assign wr_csr_lo = cfg_req.wr && (cfg_req.addr == `PPM_OFS_CSR_LO);
   assign wr_csr_hi = cfg_req.wr && (cfg_req.addr == `PPM_OFS_CSR_HI);

   // ************************************************************
   // capabilities word
   // ************************************************************
   // only bit 15 is writable; the rest is a constant pattern
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cold_wake_q <= 1'b1;
      end else if (cfg_req.wr && cfg_req.addr == `PPM_OFS_CAPS_HI) begin
         cold_wake_q <= cfg_req.wdata[7];
      end
   end

   // aux-source bit is a strap; sampled once after reset release
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         aux_src_q      <= `PPM_AUX_SRC_DFLT;
         aux_src_init_q <= 1'b0;
      end else if (!aux_src_init_q) begin
         aux_src_q      <= `PPM_AUX_SRC_DFLT;
         aux_src_init_q <= 1'b1;
      end
   end

   // bits 14:11, 10, 9, 5 set; 8:6, 3 clear; 2:0 = 010
   always_comb begin
      caps = `PPM_CAPS_FIXED;
      caps[`PPM_CAP_COLD_BIT] = cold_wake_q;
      caps[`PPM_AUX_SRC_BIT]  = aux_src_q;
   end

   // ************************************************************
   // control/status word
   // ************************************************************
   // only rstn clears these; the internal function reset does not
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enable_q <= 1'b0;
      end else if (wr_csr_hi) begin
         enable_q <= cfg_req.wdata[0];
      end
   end

   ppm_event_ctl u_event (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .event_req (wake_src),
      .clr_stat  (wr_csr_hi && cfg_req.wdata[7]),
      .enable    (enable_q),
      .stat_q    (stat_q),
      .wake_n_q  (wake_n_q)
   );

   ppm_cap_state u_state (
      .clk_sys      (clk_sys),
      .rstn         (rstn),
      .wr_en        (wr_csr_lo),
      .wr_state     (cfg_req.wdata[1:0]),
      .state_q      (state_q),
      .wake_pulse_q (wake_pulse)
   );

   always_comb begin
      csr.wake_event_flag   = stat_q;
      csr.wake_event_enable = enable_q;
      csr.power_state_field = state_q;
   end

   // ************************************************************
   // internal reset and preserved legacy base
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         func_rst_q <= 1'b0;
      end else begin
         func_rst_q <= wake_pulse;
      end
   end

   // legacy base survives the function reset on purpose
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         legacy_base_q <= `PPM_LEGACY_RST;
      end else if (cfg_req.wr && cfg_req.addr == `PPM_OFS_LEGACY_LO) begin
         legacy_base_q[7:0] <= cfg_req.wdata;
      end else if (cfg_req.wr && cfg_req.addr == `PPM_OFS_LEGACY_HI) begin
         legacy_base_q[15:8] <= cfg_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         power_state_q <= 2'h0;
      end else begin
         power_state_q <= state_q;
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   always_comb begin
      rd_d = 8'h00;
      unique case (cfg_req.addr)
         `PPM_OFS_CAP_ID:    rd_d = `PPM_CAP_ID_VAL;
         `PPM_OFS_NEXT_PTR:  rd_d = `PPM_NEXT_PTR_VAL;
         `PPM_OFS_CAPS_LO:   rd_d = caps[7:0];
         `PPM_OFS_CAPS_HI:   rd_d = caps[15:8];
         // bits 7:2 reserved zero
         `PPM_OFS_CSR_LO:    rd_d = {6'h00, csr.power_state_field};
         // scale and select fields carry no dynamic data
         `PPM_OFS_CSR_HI:    rd_d = {csr.wake_event_flag, 6'h00,
                                     csr.wake_event_enable};
         `PPM_OFS_LEGACY_LO: rd_d = legacy_base_q[7:0];
         `PPM_OFS_LEGACY_HI: rd_d = legacy_base_q[15:8];
         default:            rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg_rdata_q  <= 8'h00;
         cfg_rvalid_q <= 1'b0;
      end else begin
         cfg_rdata_q  <= cfg_req.rd ? rd_d : 8'h00;
         cfg_rvalid_q <= cfg_req.rd;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_next_zero;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_NEXT_PTR |=> cfg_rdata_q == 8'h00;
   endproperty
   a_next_zero: assert property (p_next_zero) else $error("next pointer not zero");

   property p_caps_lo;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_LO
         |=> (cfg_rdata_q & 8'hEF) == 8'h22;
   endproperty
   a_caps_lo: assert property (p_caps_lo) else $error("caps low byte wrong");

   property p_caps_hi;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_HI
         |=> cfg_rdata_q[6:0] == 7'h7E;
   endproperty
   a_caps_hi: assert property (p_caps_hi) else $error("caps high byte wrong");

   property p_cold_wr;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.wr && cfg_req.addr == `PPM_OFS_CAPS_HI |=> cold_wake_q == $past(cfg_req.wdata[7]);
   endproperty
   a_cold_wr: assert property (p_cold_wr) else $error("cold wake bit not written");

   property p_csr_rsvd;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CSR_HI |=> cfg_rdata_q[6:1] == 6'h00;
   endproperty
   a_csr_rsvd: assert property (p_csr_rsvd) else $error("data fields not zero");

   property p_csr_lo;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CSR_LO
         |=> cfg_rdata_q == {6'h00, $past(state_q)};
   endproperty
   a_csr_lo: assert property (p_csr_lo) else $error("state byte wrong");

   property p_keep;
      @(posedge clk_sys) disable iff (!rstn)
      func_rst_q && !cfg_req.wr |=> enable_q == $past(enable_q) && legacy_base_q == $past(legacy_base_q);
   endproperty
   a_keep: assert property (p_keep) else $error("state lost on function reset");

   property p_state_out;
      @(posedge clk_sys) disable iff (!rstn)
      wr_csr_lo |=> ##1 power_state_q == $past(cfg_req.wdata[1:0], 2);
   endproperty
   a_state_out: assert property (p_state_out) else $error("state write lost");

   property p_cold_hold;
      @(posedge clk_sys) disable iff (!rstn)
      !(cfg_req.wr && cfg_req.addr == `PPM_OFS_CAPS_HI)
         |=> $stable(cold_wake_q);
   endproperty
   a_cold_hold: assert property (p_cold_hold) else $error("cold wake bit drifted");

   property p_cold_read;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_HI
         |=> cfg_rdata_q[7] == $past(cold_wake_q);
   endproperty
   a_cold_read: assert property (p_cold_read) else $error("cold wake read wrong");

   property p_state_caps;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_HI
         |=> cfg_rdata_q[2:1] == 2'h3;
   endproperty
   a_state_caps: assert property (p_state_caps) else $error("state support bits");

   property p_caps_rsvd;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_HI
         |=> !cfg_rdata_q[0];
   endproperty
   a_caps_rsvd: assert property (p_caps_rsvd) else $error("reserved caps bit set");

   property p_dsi;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_LO
         |=> cfg_rdata_q[5];
   endproperty
   a_dsi: assert property (p_dsi) else $error("init bit clear");

   property p_aux;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CAPS_LO
         |=> cfg_rdata_q[4] == `PPM_AUX_SRC_DFLT;
   endproperty
   a_aux: assert property (p_aux) else $error("aux source bit wrong");

   property p_state_any;
      @(posedge clk_sys) disable iff (!rstn)
      wr_csr_lo
         |=> state_q == $past(cfg_req.wdata[1:0]);
   endproperty
   a_state_any: assert property (p_state_any) else $error("state not taken");

   property p_csr_kept;
      @(posedge clk_sys) disable iff (!rstn)
      func_rst_q && !wr_csr_lo && !wr_csr_hi && !wake_src
         |=> $stable(stat_q) && $stable(state_q);
   endproperty
   a_csr_kept: assert property (p_csr_kept) else $error("csr lost on reset");

   property p_rst_once;
      @(posedge clk_sys) disable iff (!rstn)
      func_rst_q
         |=> !func_rst_q;
   endproperty
   a_rst_once: assert property (p_rst_once) else $error("reset pulse too long");

   property p_rst_cause;
      @(posedge clk_sys) disable iff (!rstn)
      wr_csr_lo && state_q == 2'h3 && cfg_req.wdata[1:0] == 2'h0
         |=> ##1 func_rst_q;
   endproperty
   a_rst_cause: assert property (p_rst_cause) else $error("reset pulse missing");

   property p_rst_only;
      @(posedge clk_sys) disable iff (!rstn)
      func_rst_q
         |-> $past(state_q, 2) == 2'h3 && $past(state_q) == 2'h0;
   endproperty
   a_rst_only: assert property (p_rst_only) else $error("spurious reset pulse");

   property p_legacy_lo;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.wr && cfg_req.addr == `PPM_OFS_LEGACY_LO
         |=> legacy_base_q[7:0] == $past(cfg_req.wdata);
   endproperty
   a_legacy_lo: assert property (p_legacy_lo) else $error("legacy low lost");

   property p_flag_read;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CSR_HI
         |=> cfg_rdata_q[7] == $past(stat_q);
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

   property p_zero_keeps;
      @(posedge clk_sys) disable iff (!rstn)
      wr_csr_hi && !cfg_req.wdata[7] && stat_q
         |=> stat_q;
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared");

   property p_en_write;
      @(posedge clk_sys) disable iff (!rstn)
      wr_csr_hi
         |=> enable_q == $past(cfg_req.wdata[0]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable not taken");

   property p_en_read;
      @(posedge clk_sys) disable iff (!rstn)
      cfg_req.rd && cfg_req.addr == `PPM_OFS_CSR_HI
         |=> cfg_rdata_q[0] == $past(enable_q);
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable read wrong");

   property p_state_hold;
      @(posedge clk_sys) disable iff (!rstn)
      !wr_csr_lo
         |=> $stable(state_q);
   endproperty
   a_state_hold: assert property (p_state_hold) else $error("state drifted");

   property p_pin_low;
      @(posedge clk_sys) disable iff (!rstn)
      stat_q && enable_q
         |=> !wake_n_q;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("event pin not low");
endmodule // ppm_top
`default_nettype wire
